// *** logic/pcp_pll_ctrl.sv ***
// Digital model of the loop control port: dividers, oscillator, detector, lock and APB registers.
`include "pcp_cfg.svh"

module pcp_pll_ctrl (
	input  wire logic        ref_clk,          // System clock, 10 MHz.
	input  wire logic        reset_n,          // Asynchronous reset, active low.
	input  wire logic        ref_clk_pri,      // Primary reference clock pin.
	input  wire logic        ref_clk_sec,      // Secondary reference clock pin.
	input  wire logic        pll_enable,       // Loop enable and reset, active high.
	input  wire logic        counter_reset,    // Counter reset, active high.
	input  wire logic        detector_enable,  // Phase detector enable, active high.
	input  wire logic        switchover,       // Manual reference switchover request.
	output logic             post_scale_out_0, // Global clock output 0.
	output logic             post_scale_out_1, // Global clock output 1.
	output logic             post_scale_out_2, // Global clock output 2.
	output logic             ext_clk_out,      // External clock pin, copy of output 2.
	output logic             locked,           // Lock status.
	output logic             active_ref,       // 0 primary, 1 secondary reference.
	output logic             irq,              // Level interrupt.
	input  wire logic        psel,             // APB select.
	input  wire logic        penable,          // APB enable.
	input  wire logic        pwrite,           // APB direction.
	input  wire logic [11:0] paddr,            // APB byte address.
	input  wire logic [31:0] pwdata,           // APB write data.
	output logic      [31:0] prdata,           // APB read data.
	output logic             pready,           // APB ready.
	output logic             pslverr           // APB error on unmapped address.
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = (a == `PCP_ADDR_DIV) || (a == `PCP_ADDR_STATUS) ||
			(a == `PCP_ADDR_INT_STAT) || (a == `PCP_ADDR_INT_MASK);
	endfunction

	function automatic logic [4:0] post_scale_sel(input logic [31:0] d, input int idx);
		post_scale_sel = d[`PCP_DIV_C_LSB + `PCP_DIV_C_STRIDE * idx +: 5];
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Every control and reference pin is asynchronous, so each passes two flops first.
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
		end else begin
			sync1_reg <= {switchover, detector_enable, counter_reset, pll_enable, ref_clk_sec, ref_clk_pri};
			sync2_reg <= sync1_reg;
		end
	end

	logic run;
	logic pfd_en;
	logic sw_s;
	assign run    = sync2_reg[2] & ~sync2_reg[3];
	assign pfd_en = sync2_reg[4];
	assign sw_s   = sync2_reg[5];

	// ----------------------------------------------------------------
	// Registers written by software
	// ----------------------------------------------------------------
	logic        wr_en;
	logic        div_wr;
	logic [31:0] div_reg;
	logic [2:0]  int_stat_reg;
	logic [2:0]  int_mask_reg;
	logic [2:0]  int_event;

	assign wr_en  = psel & penable & pwrite;
	assign div_wr = wr_en & (paddr == `PCP_ADDR_DIV);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= `PCP_DIV_RESET;
		end else if (div_wr) begin
			div_reg <= {10'h000, pwdata[21:0]};
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			int_mask_reg <= 3'h0;
		end else if (wr_en && paddr == `PCP_ADDR_INT_MASK) begin
			int_mask_reg <= pwdata[2:0];
		end
	end

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			int_stat_reg <= 3'h0;
		end else if (wr_en && paddr == `PCP_ADDR_INT_STAT) begin
			int_stat_reg <= (int_stat_reg & ~pwdata[2:0]) | int_event;
		end else begin
			int_stat_reg <= int_stat_reg | int_event;
		end
	end

	assign irq = |(int_stat_reg & int_mask_reg);

	// ----------------------------------------------------------------
	// Reference selection and pre-scale divider
	// ----------------------------------------------------------------
	logic       sw_prev_reg;
	logic       ref_sel_reg;
	logic       ref_prev_reg;
	logic [1:0] pre_cnt_reg;
	logic       sw_req;
	logic       ref_cur;
	logic       ref_rise;
	logic       ref_tick;

	assign sw_req   = sw_s & ~sw_prev_reg;
	assign ref_cur  = ref_sel_reg ? sync2_reg[1] : sync2_reg[0];
	assign ref_rise = ref_cur & ~ref_prev_reg;
	assign ref_tick = run & ref_rise & (pre_cnt_reg == div_reg[`PCP_DIV_N_LSB +: 2]);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_prev_reg <= 1'b0;
			ref_sel_reg <= 1'b0;
		end else begin
			sw_prev_reg <= sw_s;
			if (sw_req) begin
				ref_sel_reg <= ~ref_sel_reg;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_prev_reg <= 1'b0;
			pre_cnt_reg  <= 2'h0;
		end else begin
			ref_prev_reg <= ref_cur;
			if (!run) begin
				pre_cnt_reg <= 2'h0;
			end else if (ref_tick) begin
				pre_cnt_reg <= 2'h0;
			end else if (ref_rise) begin
				pre_cnt_reg <= pre_cnt_reg + 2'h1;
			end
		end
	end

	assign active_ref = ref_sel_reg;

	// ----------------------------------------------------------------
	// Oscillator and feedback counter
	// ----------------------------------------------------------------
	logic [15:0] acc_reg;
	logic [15:0] step_reg;
	logic [6:0]  fb_cnt_reg;
	logic [16:0] acc_sum;
	logic        vco_tick;
	logic [6:0]  fb_target;
	logic        pfd_up;
	logic        pfd_dn;
	logic        fb_close;
	pcp_pkg::pcp_state_e state_reg;
	pcp_pkg::pcp_state_e state_next;

	// Each oscillator tick is a half period, so one feedback period is 2*m ticks.
	assign acc_sum   = {1'b0, acc_reg} + {1'b0, step_reg};
	assign vco_tick  = run & (state_reg != pcp_pkg::PCP_OFF) & acc_sum[16];
	assign fb_target = {1'b0, div_reg[`PCP_DIV_M_LSB +: 5], 1'b0} + 7'h02;
	assign pfd_up    = ref_tick & pfd_en & (fb_cnt_reg < fb_target);
	assign pfd_dn    = ref_tick & pfd_en & (fb_cnt_reg > fb_target);
	assign fb_close  = (fb_cnt_reg + 7'h01 >= fb_target) && (fb_cnt_reg <= fb_target + 7'h01);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_reg <= 16'h0000;
		end else if (!run || state_reg == pcp_pkg::PCP_OFF) begin
			acc_reg <= 16'h0000;
		end else begin
			acc_reg <= acc_sum[15:0];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			step_reg <= `PCP_STEP_RESET;
		end else if (!run) begin
			step_reg <= `PCP_STEP_RESET;
		end else if (pfd_up && step_reg < `PCP_STEP_MAX) begin
			step_reg <= step_reg + `PCP_STEP_GAIN;
		end else if (pfd_dn && step_reg > `PCP_STEP_MIN) begin
			step_reg <= step_reg - `PCP_STEP_GAIN;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fb_cnt_reg <= 7'h00;
		end else if (!run || ref_tick) begin
			fb_cnt_reg <= {6'h00, vco_tick};
		end else if (vco_tick && fb_cnt_reg != 7'h7F) begin
			fb_cnt_reg <= fb_cnt_reg + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Lock sequence
	// ----------------------------------------------------------------
	logic [3:0] lock_cnt_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pcp_pkg::PCP_OFF: begin
				state_next = pcp_pkg::PCP_ACQUIRE;
			end
			pcp_pkg::PCP_ACQUIRE: begin
				if (ref_tick && fb_close && lock_cnt_reg == `PCP_LOCK_EDGES - 4'h1) begin
					state_next = pcp_pkg::PCP_LOCKED;
				end
			end
			pcp_pkg::PCP_LOCKED: begin
				if (ref_tick && !fb_close) begin
					state_next = pcp_pkg::PCP_ACQUIRE;
				end
			end
			default: begin
				state_next = pcp_pkg::PCP_OFF;
			end
		endcase
		if (state_reg != pcp_pkg::PCP_OFF && (div_wr || sw_req)) begin
			state_next = pcp_pkg::PCP_ACQUIRE;
		end
		if (!run) begin
			state_next = pcp_pkg::PCP_OFF;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= pcp_pkg::PCP_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_cnt_reg <= 4'h0;
		end else if (state_next != pcp_pkg::PCP_ACQUIRE) begin
			lock_cnt_reg <= 4'h0;
		end else if (ref_tick) begin
			lock_cnt_reg <= fb_close ? lock_cnt_reg + 4'h1 : 4'h0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			locked <= 1'b0;
		end else begin
			locked <= (state_next == pcp_pkg::PCP_LOCKED);
		end
	end

	// Lock gain and loss are edges of the lock state; a switch request is an event of its own.
	assign int_event[`PCP_INT_LOCK_GAIN] = (state_next == pcp_pkg::PCP_LOCKED) && (state_reg != pcp_pkg::PCP_LOCKED);
	assign int_event[`PCP_INT_LOCK_LOSS] = (state_reg == pcp_pkg::PCP_LOCKED) && (state_next != pcp_pkg::PCP_LOCKED);
	assign int_event[`PCP_INT_SWITCH]    = sw_req;

	// ----------------------------------------------------------------
	// Post-scale counters
	// ----------------------------------------------------------------
	logic [2:0] ps_out;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_post
			logic [4:0] cnt_reg;
			logic       out_reg;

			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					cnt_reg <= 5'h00;
					out_reg <= 1'b0;
				end else if (!run) begin
					cnt_reg <= 5'h00;
					out_reg <= 1'b0;
				end else if (vco_tick) begin
					if (cnt_reg == post_scale_sel(div_reg, gi)) begin
						cnt_reg <= 5'h00;
						out_reg <= ~out_reg;
					end else begin
						cnt_reg <= cnt_reg + 5'h01;
					end
				end
			end

			assign ps_out[gi] = out_reg;
		end
	endgenerate

	assign post_scale_out_0 = ps_out[0];
	assign post_scale_out_1 = ps_out[1];
	assign post_scale_out_2 = ps_out[2];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_clk_out <= 1'b0;
		end else if (!run) begin
			ext_clk_out <= 1'b0;
		end else if (vco_tick && g_post[2].cnt_reg == post_scale_sel(div_reg, 2)) begin
			ext_clk_out <= ~ext_clk_out;
		end
	end

	// ----------------------------------------------------------------
	// APB read side
	// ----------------------------------------------------------------
	// Zero wait states: read data is captured in the setup cycle and stands through the access cycle.
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_mapped(paddr);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				`PCP_ADDR_DIV:      prdata <= div_reg;
				`PCP_ADDR_STATUS:   prdata <= {step_reg, 13'h0000, ref_sel_reg, locked, run};
				`PCP_ADDR_INT_STAT: prdata <= {29'h00000000, int_stat_reg};
				`PCP_ADDR_INT_MASK: prdata <= {29'h00000000, int_mask_reg};
				default:            prdata <= 32'h00000000;
			endcase
		end
	end

endmodule

// *** logic/pcp_cfg.svh ***
// Offsets, field positions, reset values and counts for the loop control port.
//
// Contract
// - Enable input doubles as loop enable and reset.
// - Enable low grounds outputs and drops lock.
// - Enable high restarts lock and resynchronizes loop.
// - Counter reset high holds counters, outputs, lock.
// - Counter reset released restarts lock sequence.
// - Detector enable low suppresses up/down, oscillator runs.
// - Detector disabled keeps outputs toggling; may drift.
// - Switchover input high starts manual reference change.
// - Lock output high locked, low otherwise.
// - Lock may toggle during acquisition before settling.
// - Outputs 0,1 global; output 2 also external.
// - Primary/secondary references, selected one feeds pre-scaler.
// - Pre-scale divider supports values 1 to 4.
// - Multiplier and post-scale dividers support 1 to 32.
// - Output frequency equals input times m/(n*c).
`ifndef PCP_CFG_SVH
`define PCP_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCP_ADDR_DIV      12'h000
`define PCP_ADDR_STATUS   12'h004
`define PCP_ADDR_INT_STAT 12'h008
`define PCP_ADDR_INT_MASK 12'h00C

// ----------------------------------------------------------------
// Divider register fields, each holding the setting minus one
// ----------------------------------------------------------------
`define PCP_DIV_N_LSB     0
`define PCP_DIV_M_LSB     2
`define PCP_DIV_C_LSB     7
`define PCP_DIV_C_STRIDE  5
`define PCP_DIV_RESET     32'h00000000

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define PCP_INT_LOCK_GAIN 0
`define PCP_INT_LOCK_LOSS 1
`define PCP_INT_SWITCH    2

// ----------------------------------------------------------------
// Oscillator and lock detector
// ----------------------------------------------------------------
`define PCP_STEP_RESET    16'h1000
`define PCP_STEP_GAIN     16'h0010
`define PCP_STEP_MIN      16'h0020
`define PCP_STEP_MAX      16'hFFE0
`define PCP_LOCK_EDGES    4'h4

`endif

// *** logic/pcp_pkg.sv ***
// Types shared by the loop control port logic.
package pcp_pkg;

	typedef enum logic [1:0] {
		PCP_OFF,
		PCP_ACQUIRE,
		PCP_LOCKED
	} pcp_state_e;

endpackage

// *** bench/pcp_ref_src.sv ***
// Reference clock pins that feed the loop, stoppable by the bench.
module pcp_ref_src (
	input  wire logic ref_clk,            // System clock.
	input  wire logic run,                // Pins toggle while high.
	output logic      ref_clk_pri = 1'b0, // Primary pin, 8 cycles high, 8 low.
	output logic      ref_clk_sec = 1'b0  // Secondary pin, 12 cycles high, 12 low.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_p = 5'h00;
	logic [4:0] cnt_s = 5'h00;
	// A stopped pin stands still low, as an idle clock source does.
	always @(posedge ref_clk) begin
		cnt_p <= (!run || cnt_p == 5'h07) ? 5'h00 : cnt_p + 5'h01;
		cnt_s <= (!run || cnt_s == 5'h0B) ? 5'h00 : cnt_s + 5'h01;
		if (!run) begin
			ref_clk_pri <= 1'b0;
			ref_clk_sec <= 1'b0;
		end else begin
			if (cnt_p == 5'h07)
				ref_clk_pri <= ~ref_clk_pri;
			if (cnt_s == 5'h0B)
				ref_clk_sec <= ~ref_clk_sec;
		end
	end
endmodule

// *** bench/pcp_pll_ctrl_monitor.sv ***
// Concurrent checks on the loop control port pins.
module pcp_pll_ctrl_monitor (
	input wire logic        ref_clk,          // Clock.
	input wire logic        reset_n,          // Reset.
	input wire logic        pll_enable,       // Loop enable.
	input wire logic        counter_reset,    // Counter hold.
	input wire logic        detector_enable,  // Detector on.
	input wire logic        switchover,       // Switch request.
	input wire logic        post_scale_out_0, // Output 0.
	input wire logic        post_scale_out_1, // Output 1.
	input wire logic        post_scale_out_2, // Output 2.
	input wire logic        ext_clk_out,      // Pin copy.
	input wire logic        locked,           // Lock.
	input wire logic        active_ref,       // Reference in use.
	input wire logic        psel,             // Select.
	input wire logic        penable,          // Enable.
	input wire logic [11:0] paddr,            // Address.
	input wire logic        pready,           // Ready.
	input wire logic        pslverr           // Error.
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	logic        busy;
	logic [11:0] still_cnt;
	assign busy = post_scale_out_0 | post_scale_out_1 | post_scale_out_2 | ext_clk_out | locked;
	// Counts cycles in which output 0 stands still while the loop runs without its detector.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			still_cnt <= 12'h000;
		else if (pll_enable && !counter_reset && !detector_enable && !$changed(post_scale_out_0))
			still_cnt <= still_cnt + 12'h001;
		else
			still_cnt <= 12'h000;
	end
	a_off_quiet: assert property (!pll_enable [*5] |-> !busy)
		else $error("output active while loop disabled");
	a_hold_quiet: assert property (counter_reset [*5] |-> !busy)
		else $error("output active while counters held");
	a_pin_mirror: assert property (ext_clk_out == post_scale_out_2)
		else $error("external pin differs from output 2");
	a_lock_cause: assert property (locked |-> $past(pll_enable, 4) && !$past(counter_reset, 4))
		else $error("lock shown while loop not running");
	a_enable_restart: assert property (!pll_enable [*5] ##1 pll_enable |=> !locked [*8])
		else $error("lock shown right after enable");
	a_hold_restart: assert property (counter_reset [*5] ##1 !counter_reset |=> !locked [*8])
		else $error("lock shown right after counter release");
	a_switch_acts: assert property ($rose(switchover) |-> ##[1:6] $changed(active_ref))
		else $error("switch request ignored");
	a_free_run: assert property (still_cnt < 12'hBB8)
		else $error("outputs stopped with detector off");
	a_bus_answer: assert property (psel && penable |-> pready && pslverr == !(paddr == 12'h000 ||
		paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C))
		else $error("wrong bus response");
	c_lock: cover property ($rose(locked));
	c_switch: cover property ($changed(active_ref));
	c_bad: cover property (psel && penable && pslverr);
endmodule

bind pcp_pll_ctrl pcp_pll_ctrl_monitor mon (.ref_clk, .reset_n, .pll_enable, .counter_reset, .detector_enable,
	.switchover, .post_scale_out_0, .post_scale_out_1, .post_scale_out_2, .ext_clk_out, .locked, .active_ref,
	.psel, .penable, .paddr, .pready, .pslverr);

// *** bench/test_pll_control_port_logic.sv ***
// Self-checking bench for the loop control port and its register bus.
module test_pll_control_port_logic;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HALF = 8, N = 2, M = 1, C0 = 1, C1 = 2, C2 = 3, WIN = 960;
	localparam logic [31:0] DIV = 32'((N - 1) | ((M - 1) << 2) | ((C0 - 1) << 7) | ((C1 - 1) << 12) | ((C2 - 1) << 17));
	logic        ref_clk = 1'b0, reset_n = 1'b0, pll_enable = 1'b0, counter_reset = 1'b0;
	logic        detector_enable = 1'b1, switchover = 1'b0, ref_run = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
	logic        ref_clk_pri, ref_clk_sec, post_scale_out_0, post_scale_out_1, post_scale_out_2;
	logic        ext_clk_out, locked, active_ref, irq, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rdata;
	int          n_mismatch = 0, comparisons = 0;

	pcp_ref_src far (.ref_clk, .run(ref_run), .ref_clk_pri, .ref_clk_sec);
	pcp_pll_ctrl dut (.ref_clk, .reset_n, .ref_clk_pri, .ref_clk_sec, .pll_enable, .counter_reset,
		.detector_enable, .switchover, .post_scale_out_0, .post_scale_out_1, .post_scale_out_2, .ext_clk_out,
		.locked, .active_ref, .irq, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		$display("%0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_up(input string what);
		n_mismatch++;
		$display("unexpected at %0t ns: %s", $time, what);
		test_done();
	endtask

	task automatic note(input string s);
		$display("%0t ns: test %s over", $time, s);
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16)
			give_up("bus hang");
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle cycle lets a written register settle before the caller looks at it.
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
		apb(1'b0, a, 32'h00000000);
		check(rdata & msk, exp);
	endtask

	task automatic wait_lock();
		int k, good;
		good = 0;
		for (k = 0; k < 12000 && good < 64; k++) begin
			@(posedge ref_clk);
			good = (locked === 1'b1) ? good + 1 : 0;
		end
		if (good < 64)
			give_up("no lock");
	endtask

	function automatic logic near(input int n, input int e);
		return n >= e - 2 && n <= e + 2;
	endfunction

	task automatic measure();
		int n[3];
		logic [2:0] p, c;
		n = '{0, 0, 0};
		p = 3'h7;
		repeat (WIN) begin
			@(posedge ref_clk);
			c = {post_scale_out_2, post_scale_out_1, post_scale_out_0};
			for (int i = 0; i < 3; i++)
				n[i] += int'(c[i] & ~p[i]);
			p = c;
		end
		check({29'h0, near(n[2], WIN * M / (2 * HALF * N * C2)), near(n[1], WIN * M / (2 * HALF * N * C1)),
			near(n[0], WIN * M / (2 * HALF * N * C0))}, 32'h00000007);
	endtask

	task automatic held_off();
		repeat (6) @(posedge ref_clk);
		check({27'h0, post_scale_out_0, post_scale_out_1, post_scale_out_2, ext_clk_out, locked}, 32'h0);
	endtask

	task automatic pulse_switch();
		switchover <= 1'b1;
		repeat (6) @(posedge ref_clk);
		switchover <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd(12'h000, 32'h0, 32'hFFFFFFFF);
		rd(12'h004, 32'h0, 32'h0000FFFF);
		rd(12'h008, 32'h0, 32'hFFFFFFFF);
		rd(12'h00C, 32'h0, 32'hFFFFFFFF);
		rd(12'h010, 32'h0, 32'hFFFFFFFF);
		check({31'h0, rerr}, 32'h1);
		apb(1'b1, 12'h000, DIV);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		rd(12'h000, DIV, 32'hFFFFFFFF);
		note("registers");
		pll_enable <= 1'b1;
		wait_lock();
		rd(12'h004, 32'h3, 32'h7);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, 12'h00C, 32'h1);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, 12'h008, 32'h1);
		rd(12'h008, 32'h0, 32'h1);
		check({31'h0, irq}, 32'h0);
		measure();
		note("lock and interrupt");
		ref_run <= 1'b0;
		detector_enable <= 1'b0;
		measure();
		detector_enable <= 1'b1;
		ref_run <= 1'b1;
		wait_lock();
		note("detector off");
		apb(1'b1, 12'h00C, 32'h4);
		pulse_switch();
		check({30'h0, irq, active_ref}, 32'h3);
		rd(12'h004, 32'h4, 32'h4);
		wait_lock();
		pulse_switch();
		check({31'h0, active_ref}, 32'h0);
		apb(1'b1, 12'h008, 32'h7);
		check({31'h0, irq}, 32'h0);
		wait_lock();
		note("switchover");
		counter_reset <= 1'b1;
		held_off();
		rd(12'h004, 32'h0, 32'h3);
		rd(12'h008, 32'h2, 32'h2);
		counter_reset <= 1'b0;
		wait_lock();
		pll_enable <= 1'b0;
		held_off();
		pll_enable <= 1'b1;
		wait_lock();
		measure();
		note("hold and disable");
		test_done();
	end
endmodule
